// [hdl/tcs_sequencer.sv]
// Top level charge, ready, clean and abort sequencer of the torch cleaner.

// Overview of operation
// RQ1: After reset the capacitors stay discharged and robot outputs are low.
// RQ2: Charging begins only while the run permit is asserted.
// RQ3: Temperature is checked before every charge and must be in range.
// RQ4: Overtemperature lights its lamp and holds charging off until it clears; the code holds only at the TCS_TEMP check, not during charge or ready.
// RQ5: Ready rises after twenty seconds of charging and the lamp flashes.
// RQ6: The charge state lamp turns steady at full charge.
// RQ7: Full charge is reached after fifty seconds of continuous charging.
// RQ8: A robot clean trigger while ready starts a cleaning discharge.
// RQ9: The local discharge button starts the same cleaning cycle.
// RQ10: After cleaning the sequence rechecks temperature and recharges.
// RQ11: A fault during cleaning asserts the error output.
// RQ12: After recharging a new trigger is taken only once ready is high again.
// RQ13: Loss of run permit aborts at once and discharges through the coil.
// RQ14: Low fluid level lights its lamp and drives the low level output.
// RQ15: Low fluid level never blocks charging, ready or cleaning.
// RQ16: Ready drops at cleaning start or abort and stays low until recharged.
// RQ17: Triggers are ignored while ready is low or run permit is absent.
module tcs_sequencer #(
    parameter int unsigned TICK_DIV = tcs_pkg::TICK_CYCLES
) (
    input  wire logic CLK_SYS_IN,         // System clock, 250 MHz.
    input  wire logic RESET_IN,           // Synchronous reset, active high.
    input  wire logic RUN_PERMIT_IN,      // Run permit from robot.
    input  wire logic CLEAN_START_IN,     // Clean trigger from robot.
    input  wire logic BUTTON_IN,          // Local discharge button.
    input  wire logic TEMP_OK_IN,         // Temperature within range.
    input  wire logic LEVEL_LOW_IN,       // Level sensor reports low.
    input  wire logic CLEAN_FAULT_IN,     // Fault seen during cleaning.
    output logic      MAINS_LAMP_OUT,     // Mains present indicator.
    output logic      CHARGE_EN_OUT,      // Capacitor charger enable.
    output logic      DISCHARGE_OUT,      // Discharge through the coil.
    output logic      READY_OUT,          // Ready to robot.
    output logic      ERROR_OUT,          // Cleaning error to robot.
    output logic      LEVEL_OUT,          // Low level to robot.
    output logic      LEVEL_LAMP_OUT,     // Fill level indicator.
    output logic      OVERTEMP_LAMP_OUT,  // Overtemperature indicator.
    output logic      CHARGE_STATE_LAMP_OUT // Charge state lamp.
);
    import tcs_pkg::*;

    logic tick;
    logic [1:0] permit_sync_reg, start_sync_reg, button_sync_reg;
    logic [1:0] temp_sync_reg, level_sync_reg, fault_sync_reg;
    logic       trig_prev_reg;
    logic       permit, temp_ok, level_low, fault, trig_lvl, trig_rise;

    tcs_state_t     state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [CNT_W-1:0] flash_reg, flash_next;
    logic           blink_reg, blink_next;
    logic           full_reg, full_next;
    logic           error_reg, error_next;

    // Slow tick for all second-scale timing.
    tcs_tick_div #(.DIV(TICK_DIV)) u_div (
        .CLK_SYS_IN (CLK_SYS_IN),
        .RESET_IN   (RESET_IN),
        .TICK_OUT   (tick)
    );

    // Pin inputs pass two flip-flops before any logic reads them.
    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            permit_sync_reg <= 2'h0;
            start_sync_reg  <= 2'h0;
            button_sync_reg <= 2'h0;
            temp_sync_reg   <= 2'h0;
            level_sync_reg  <= 2'h0;
            fault_sync_reg  <= 2'h0;
            trig_prev_reg   <= 1'b0;
        end else begin
            permit_sync_reg <= {permit_sync_reg[0], RUN_PERMIT_IN};
            start_sync_reg  <= {start_sync_reg[0], CLEAN_START_IN};
            button_sync_reg <= {button_sync_reg[0], BUTTON_IN};
            temp_sync_reg   <= {temp_sync_reg[0], TEMP_OK_IN};
            level_sync_reg  <= {level_sync_reg[0], LEVEL_LOW_IN};
            fault_sync_reg  <= {fault_sync_reg[0], CLEAN_FAULT_IN};
            trig_prev_reg   <= trig_lvl;
        end
    end

    assign permit    = permit_sync_reg[1];
    assign temp_ok   = temp_sync_reg[1];
    assign level_low = level_sync_reg[1];
    assign fault     = fault_sync_reg[1];
    // A held trigger must not restart cleaning, so only a rising edge counts.
    assign trig_lvl  = start_sync_reg[1] | button_sync_reg[1]; // RQ9
    assign trig_rise = trig_lvl & ~trig_prev_reg;

    // Sequence next state; permit loss overrides every state except idle and abort.
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        full_next  = full_reg;
        error_next = error_reg;
        flash_next = flash_reg;
        blink_next = blink_reg;
        if (tick) begin
            if (flash_reg == CNT_W'(FLASH_TICKS - 1)) begin
                flash_next = CNT_RESET;
                blink_next = ~blink_reg;
            end else begin
                flash_next = flash_reg + 10'h001;
            end
        end
        unique case (state_reg)
            TCS_IDLE: begin
                if (permit) state_next = TCS_TEMP; // RQ2
            end
            TCS_TEMP: begin
                cnt_next  = CNT_RESET;
                full_next = 1'b0;
                if (temp_ok) state_next = TCS_CHARGE; // RQ3 RQ4
            end
            TCS_CHARGE: begin
                if (tick) cnt_next = cnt_reg + 10'h001;
                if (tick && cnt_reg == CNT_W'(READY_TICKS - 1)) begin
                    state_next = TCS_READY; // RQ5 RQ15
                    blink_next = 1'b1;
                    flash_next = CNT_RESET;
                end
            end
            TCS_READY: begin
                if (tick && !full_reg) cnt_next = cnt_reg + 10'h001;
                if (tick && cnt_reg == CNT_W'(FULL_TICKS - 1))
                    full_next = 1'b1; // RQ7
                if (trig_rise) begin
                    state_next = TCS_CLEAN; // RQ8 RQ12 RQ16
                    cnt_next   = CNT_RESET;
                    error_next = 1'b0;
                end
            end
            TCS_CLEAN: begin
                if (fault) error_next = 1'b1; // RQ11
                if (tick) cnt_next = cnt_reg + 10'h001;
                if (tick && cnt_reg == CNT_W'(DISCH_TICKS - 1))
                    state_next = TCS_TEMP; // RQ10
            end
            TCS_ABORT: begin
                if (tick) cnt_next = cnt_reg + 10'h001;
                if (tick && cnt_reg == CNT_W'(DISCH_TICKS - 1))
                    state_next = TCS_IDLE;
            end
            default: state_next = TCS_IDLE;
        endcase
        if (!permit && state_reg != TCS_IDLE && state_reg != TCS_ABORT) begin
            state_next = TCS_ABORT; // RQ13 RQ17
            cnt_next   = CNT_RESET;
            full_next  = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            state_reg <= TCS_IDLE;
            cnt_reg   <= CNT_RESET;
            full_reg  <= 1'b0;
            error_reg <= 1'b0;
            flash_reg <= CNT_RESET;
            blink_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            full_reg  <= full_next;
            error_reg <= error_next;
            flash_reg <= flash_next;
            blink_reg <= blink_next;
        end
    end

    // State outputs are registered copies of the next state, so none lags.
    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            MAINS_LAMP_OUT        <= 1'b1; // RQ1
            CHARGE_EN_OUT         <= 1'b0;
            DISCHARGE_OUT         <= 1'b1;
            READY_OUT             <= 1'b0;
            ERROR_OUT             <= 1'b0;
            LEVEL_OUT             <= 1'b0;
            LEVEL_LAMP_OUT        <= 1'b0;
            OVERTEMP_LAMP_OUT     <= 1'b0;
            CHARGE_STATE_LAMP_OUT <= 1'b0;
        end else begin
            MAINS_LAMP_OUT    <= 1'b1;
            CHARGE_EN_OUT     <= (state_next == TCS_CHARGE) ||
                                 (state_next == TCS_READY);
            // Idle holds the bank shorted; abort is the safety dump.
            DISCHARGE_OUT     <= (state_next == TCS_IDLE) ||
                                 (state_next == TCS_ABORT) ||
                                 (state_next == TCS_CLEAN); // RQ1 RQ13
            READY_OUT         <= (state_next == TCS_READY); // RQ16
            ERROR_OUT         <= error_next; // RQ11
            LEVEL_OUT         <= level_low; // RQ14
            LEVEL_LAMP_OUT    <= level_low; // RQ14
            OVERTEMP_LAMP_OUT <= ~temp_ok; // RQ4
            CHARGE_STATE_LAMP_OUT <= (state_next == TCS_READY) &&
                                     (full_next | blink_next); // RQ5 RQ6
        end
    end

    ready_drop_a: assert property ( // RQ16
        @(posedge CLK_SYS_IN) disable iff (RESET_IN)
        (state_reg == TCS_CLEAN) |-> ##1 !READY_OUT)
        else $error("ready high during cleaning");
    // Permit loss in any state must show as a dump with the charger off.
    abort_disch_a: assert property ( // RQ13
        @(posedge CLK_SYS_IN) disable iff (RESET_IN)
        !permit |=> DISCHARGE_OUT && !READY_OUT && !CHARGE_EN_OUT)
        else $error("no safety discharge on permit loss");
    temp_gate_a: assert property ( // RQ3
        @(posedge CLK_SYS_IN) disable iff (RESET_IN)
        $rose(CHARGE_EN_OUT) |-> $past(temp_ok))
        else $error("charge started out of temperature");
    permit_gate_a: assert property ( // RQ2
        @(posedge CLK_SYS_IN) disable iff (RESET_IN)
        $rose(CHARGE_EN_OUT) |-> $past(permit))
        else $error("charge without permit");
    level_pair_a: assert property ( // RQ14
        @(posedge CLK_SYS_IN) disable iff (RESET_IN)
        LEVEL_OUT == LEVEL_LAMP_OUT)
        else $error("level lamp and output differ");
    clean_gate_a: assert property ( // RQ17 RQ12
        @(posedge CLK_SYS_IN) disable iff (RESET_IN)
        (state_reg != TCS_CLEAN ##1 state_reg == TCS_CLEAN) |->
        $past(READY_OUT))
        else $error("cleaning without ready");
    lamp_steady_a: assert property ( // RQ6
        @(posedge CLK_SYS_IN) disable iff (RESET_IN)
        (full_reg && state_reg == TCS_READY) |=> CHARGE_STATE_LAMP_OUT ||
        !READY_OUT)
        else $error("lamp not steady at full charge");
    // The last discharge tick with permit present must land in the check.
    clean_return_a: assert property ( // RQ10
        @(posedge CLK_SYS_IN) disable iff (RESET_IN)
        (state_reg == TCS_CLEAN && tick && permit &&
         cnt_reg == CNT_W'(DISCH_TICKS - 1)) |=>
        (state_reg == TCS_TEMP) && !DISCHARGE_OUT)
        else $error("cleaning did not return to check");
    // Ready may only rise on the tick that ends the ready time of charging.
    ready_clear_a: assert property ( // RQ5
        @(posedge CLK_SYS_IN) disable iff (RESET_IN)
        $rose(READY_OUT) |->
        $past(tick) && ($past(cnt_reg) == CNT_W'(READY_TICKS - 1)))
        else $error("ready before the ready time");
    c_ready_c: cover property (@(posedge CLK_SYS_IN) $rose(READY_OUT));
    c_full_c: cover property (@(posedge CLK_SYS_IN) $rose(full_reg));
    c_clean_c: cover property (@(posedge CLK_SYS_IN) state_reg == TCS_CLEAN);
    c_abort_c: cover property (@(posedge CLK_SYS_IN) state_reg == TCS_ABORT);
endmodule : tcs_sequencer

// [hdl/tcs_pkg.sv]
// Package of constants and types for the torch cleaner charge sequencer.
package tcs_pkg;
    localparam int unsigned CLK_HZ          = 250_000_000;
    // Slow tick period in milliseconds and its cycle count.
    localparam int unsigned TICK_MS         = 100;
    localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
    // Charging times in seconds and their counts of slow ticks.
    localparam int unsigned READY_TIME_S    = 20;
    localparam int unsigned FULL_TIME_S     = 50;
    localparam int unsigned READY_TICKS     = READY_TIME_S * 1000 / TICK_MS;
    localparam int unsigned FULL_TICKS      = FULL_TIME_S * 1000 / TICK_MS;
    // Discharge pulse length and flash half period, in slow ticks.
    localparam int unsigned DISCH_TICKS     = 5;
    localparam int unsigned FLASH_TICKS     = 5;
    localparam int unsigned CNT_W           = 10;
    localparam logic [CNT_W-1:0] CNT_RESET  = 10'h000;

    typedef enum logic [2:0] {
        TCS_IDLE   = 3'b000,
        TCS_TEMP   = 3'b001,
        TCS_CHARGE = 3'b010,
        TCS_READY  = 3'b011,
        TCS_CLEAN  = 3'b100,
        TCS_ABORT  = 3'b101
    } tcs_state_t;
endpackage : tcs_pkg

// [hdl/tcs_tick_div.sv]
// Divider that makes the one-cycle slow tick enable.
module tcs_tick_div #(
    parameter int unsigned DIV = tcs_pkg::TICK_CYCLES
) (
    input  wire logic CLK_SYS_IN,   // System clock.
    input  wire logic RESET_IN,     // Synchronous reset, active high.
    output logic      TICK_OUT      // One-cycle slow tick.
);
    import tcs_pkg::*;
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic        tick_next;

    // Count down to zero, then reload and pulse the tick.
    always_comb begin
        tick_next = (cnt_reg == 32'h0000_0000);
        cnt_next  = tick_next ? 32'(DIV - 1) : cnt_reg - 32'h0000_0001;
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            cnt_reg  <= 32'h0000_0000;
            TICK_OUT <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            TICK_OUT <= tick_next;
        end
    end
endmodule : tcs_tick_div

// [dv/tcs_robot_model.sv]
// Behavioural model of the robot controller on the discrete lines.
module tcs_robot_model (
    input  wire logic clk_in,        // Bench clock.
    input  wire logic ready_in,      // Ready seen from the unit.
    input  wire logic permit_cmd_in, // Bench asks for run permit.
    input  wire logic clean_cmd_in,  // Bench asks for a cleaning.
    output logic      permit_out,    // Run permit line.
    output logic      start_out      // Clean trigger line.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic permit_req;                // Permit command taken at the last edge.
    logic clean_req;                 // Trigger request taken at the last edge.
    // The robot only triggers once ready is seen, as a real cell would.
    // Requests are taken on the rising edge, where the bench's falling-edge
    // commands have settled, so the model never races the bench.
    always @(posedge clk_in) begin
        permit_req <= permit_cmd_in;
        clean_req  <= clean_cmd_in & ready_in;
    end
    // Lines to the unit change on the falling edge only.
    always @(negedge clk_in) begin
        permit_out <= permit_req;
        start_out  <= clean_req;
    end
endmodule // tcs_robot_model

// [dv/tcs_sequencer_tb.sv]
// Self-checking bench for the torch cleaner charge sequencer.
module tcs_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tcs_pkg::*;
    // A short tick keeps the twenty and fifty second counts affordable.
    localparam int DIV = 4;
    localparam int RDY_CYC = READY_TICKS * DIV;
    localparam int FULL_CYC = FULL_TICKS * DIV;
    logic clk = 1'b0, rst = 1'b1, permit_cmd = 1'b0, clean_cmd = 1'b0;
    logic button = 1'b0, temp_ok = 1'b1, level_low = 1'b0, fault = 1'b0;
    logic permit, start, mains, chg, dis, rdy, err, lvl, lvl_lamp, ot, lamp;
    int errors = 0, check_count = 0, cycles = 0, n, t;
    // Clock of 4 ns period.
    always #2 clk = ~clk;
    tcs_robot_model robot_u (.clk_in(clk), .ready_in(rdy),
        .permit_cmd_in(permit_cmd), .clean_cmd_in(clean_cmd),
        .permit_out(permit), .start_out(start));
    tcs_sequencer #(.TICK_DIV(DIV)) dut_u (.CLK_SYS_IN(clk),
        .RESET_IN(rst), .RUN_PERMIT_IN(permit), .CLEAN_START_IN(start),
        .BUTTON_IN(button), .TEMP_OK_IN(temp_ok),
        .LEVEL_LOW_IN(level_low), .CLEAN_FAULT_IN(fault),
        .MAINS_LAMP_OUT(mains), .CHARGE_EN_OUT(chg), .DISCHARGE_OUT(dis),
        .READY_OUT(rdy), .ERROR_OUT(err), .LEVEL_OUT(lvl),
        .LEVEL_LAMP_OUT(lvl_lamp), .OVERTEMP_LAMP_OUT(ot),
        .CHARGE_STATE_LAMP_OUT(lamp));
    task automatic stop_test;
        $display("Checks %0d, errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %b seen %b", what, e, g);
        end
    endtask
    function automatic logic sel(input int i);
        if (i == 0) return rdy;
        if (i == 1) return chg;
        return dis;
    endfunction
    // Waits at falling edges for a flag; the count tells how long it took.
    task automatic wait_for(input int i, input logic v, input int mx,
                            output int c);
        c = 0;
        while (sel(i) !== v && c < mx) begin
            @(negedge clk);
            c++;
        end
    endtask
    // Counts changes of the charge state lamp over a span of cycles.
    task automatic toggles(input int cyc, output int c);
        logic last;
        c = 0;
        last = lamp;
        repeat (cyc) begin
            @(negedge clk);
            if (lamp !== last) c++;
            last = lamp;
        end
    endtask
    task automatic t_reset;
        chk("mains", 1'b1, mains);
        chk("discharge", 1'b1, dis);
        chk("ready", 1'b0, rdy);
        chk("error", 1'b0, err);
        chk("level", 1'b0, lvl);
        rst = 1'b0;
        repeat (20) @(negedge clk);
        chk("no permit charge", 1'b0, chg);
    endtask
    task automatic t_overtemp;
        temp_ok = 1'b0;
        permit_cmd = 1'b1;
        repeat (20) @(negedge clk);
        chk("overtemp lamp", 1'b1, ot);
        chk("hot charge", 1'b0, chg);
        temp_ok = 1'b1;
        wait_for(1, 1'b1, 20, n);
        chk("charge starts", 1'b1, n < 20);
        chk("overtemp clear", 1'b0, ot);
    endtask
    task automatic t_ready;
        button = 1'b1;
        repeat (5) @(negedge clk);
        button = 1'b0;
        repeat (5) @(negedge clk);
        chk("early trigger", 1'b0, dis);
        wait_for(0, 1'b1, RDY_CYC + 40, n);
        n += 10;
        chk("ready time", 1'b1, n > RDY_CYC - 12 && n < RDY_CYC + 12);
        toggles(FULL_CYC - RDY_CYC - 40, t);
        chk("lamp flashing", 1'b1, t > 2);
        repeat (60) @(negedge clk);
        toggles(80, t);
        chk("lamp steady", 1'b1, t == 0 && lamp === 1'b1);
    endtask
    task automatic t_robot_clean;
        level_low = 1'b1;
        repeat (6) @(negedge clk);
        chk("level out", 1'b1, lvl);
        chk("level lamp", 1'b1, lvl_lamp);
        clean_cmd = 1'b1;
        wait_for(0, 1'b0, 20, n);
        clean_cmd = 1'b0;
        chk("ready drops", 1'b1, n < 20);
        chk("discharge", 1'b1, dis);
        chk("charger off", 1'b0, chg);
        wait_for(0, 1'b1, RDY_CYC + 200, n);
        t = RDY_CYC + 200;
        chk("recharged", 1'b1, n > RDY_CYC - 12 && n < t);
    endtask
    task automatic t_button_fault;
        fault = 1'b1;
        button = 1'b1;
        wait_for(2, 1'b1, 20, n);
        chk("button clean", 1'b1, n < 20);
        button = 1'b0;
        repeat (8) @(negedge clk);
        chk("error out", 1'b1, err);
        fault = 1'b0;
        wait_for(0, 1'b1, RDY_CYC + 200, n);
        chk("ready again", 1'b1, rdy);
    endtask
    task automatic t_abort;
        permit_cmd = 1'b0;
        wait_for(2, 1'b1, 12, n);
        chk("abort discharge", 1'b1, n < 12);
        chk("abort ready", 1'b0, rdy);
        chk("abort charger", 1'b0, chg);
    endtask
    // Hang guard: the whole sequence needs well under this many cycles.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            stop_test();
        end
    end
    // Main sequence, reset held for five cycles first.
    initial begin
        repeat (5) @(negedge clk);
        t_reset();
        t_overtemp();
        t_ready();
        t_robot_clean();
        t_button_fault();
        t_abort();
        stop_test();
    end
endmodule // tcs_sequencer_tb
